// ---- alarm_pkg.sv ----
// alarm monitor constants, register map and carrier types
// assumes an AXI4-Lite master with 32-bit data on the device clock
package alarm_pkg;
  localparam logic [11:0] agg_alarm_off  = 12'h2c0;
  localparam logic [11:0] fault_stat_off = 12'h2c1;
  localparam logic [11:0] fault_hide_off = 12'h2c2;
  localparam logic [11:0] lane_fault_off = 12'h2c4;
  localparam logic [11:0] link_ctrl_idx  = 12'h2c8;
  localparam logic [11:0] irq_stat_idx   = 12'h2c9;
  localparam logic [11:0] irq_mask_idx   = 12'h2ca;
  localparam logic [7:0]  stat_reset     = 8'h3f;
  localparam logic [7:0]  hide_reset     = 8'h3f;
  localparam logic [7:0]  lane_reset     = 8'hff;
  localparam logic [7:0]  stat_impl      = 8'h3d;
  localparam logic [7:0]  hide_impl      = 8'h3f;
  localparam int          bit_fifo       = 5;
  localparam int          bit_spll       = 4;
  localparam int          bit_link       = 3;
  localparam int          bit_realign    = 2;
  localparam int          bit_clk        = 0;
  localparam logic [1:0]  resp_okay      = 2'h0;
  localparam logic [1:0]  resp_slverr    = 2'h2;

  typedef struct packed {
    logic [7:0] lane_fault;
    logic       spll_unlock;
    logic       link_up_data;
    logic       realigned;
    logic       link_restart;
    logic       div_mismatch;
  } alarm_evt_s;

  typedef struct packed {
    logic       link_en;
    logic       mode_64b66b;
    logic       agg_pin_sel;
  } link_ctrl_s;
endpackage

// ---- alarm_regbank.sv ----
// sticky write-one-to-clear flag bank, set wins over clear
// assumes set and clear pulses on mclk
`timescale 1ns/100ps
module alarm_regbank #(
  parameter int        w   = 8,
  parameter logic [7:0] rst = 8'hff
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [w-1:0] set_in,
  input  wire logic [w-1:0] clr_in,
  output logic      [w-1:0] flags
);
  logic [w-1:0] flags_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= rst[w-1:0];
    end else begin
      flags_ff <= (flags_ff & ~clr_in) | set_in;
    end
  end
  assign flags = flags_ff;
endmodule

// ---- serial_link_alarm_monitor.sv ----
// alarm collection for the serial output link, AXI4-Lite register slave
// assumes event inputs are pins from other domains; they are synchronised here
`timescale 1ns/100ps
// Contract
// - lane buffer fault sets its status flag
// - serializer pll unlock sets its flag
// - 8b10b: enabled, not in data, sets flag
// - 64b66b: startup or link restart sets flag
// - sysref clock realignment sets flag
// - divider mismatch sets its flag
// - all status flags one after reset
// - flags other than divider undefined when disabled
// - mask bits hide flags, reset one
// - eight bit per-lane fault register, resets ff
// - one-write clears lane bit, may reset
// - clearing status fifo bit clears lanes
// - aggregate bit shows unmasked set flags
// - aggregate selectable onto calibration status pin
module serial_link_alarm_monitor
(
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire alarm_pkg::alarm_evt_s evt_in,
  input  wire logic                 cal_status_in,
  output logic                      calibration_status_pin,
  output logic                      irq,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import alarm_pkg::*;

  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[9:0], 2'b00};
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] idx);
    logic [11:0] ba;
    ba = byte_addr(idx);
    addr_hit = (a[11:2] == ba[11:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  alarm_evt_s evt_s1_ff;
  alarm_evt_s evt_ff;
  logic       cal_s1_ff;
  logic       cal_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      evt_s1_ff <= '0;
      evt_ff    <= '0;
      cal_s1_ff <= 1'b0;
      cal_ff    <= 1'b0;
    end else begin
      evt_s1_ff <= evt_in;
      evt_ff    <= evt_s1_ff;
      cal_s1_ff <= cal_status_in;
      cal_ff    <= cal_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        wr_go;
  logic        wr_known;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign wr_go         = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_known = addr_hit(awaddr_ff, fault_stat_off) | addr_hit(awaddr_ff, fault_hide_off)
                  | addr_hit(awaddr_ff, lane_fault_off) | addr_hit(awaddr_ff, agg_alarm_off)
                  | addr_hit(awaddr_ff, link_ctrl_idx) | addr_hit(awaddr_ff, irq_stat_idx)
                  | addr_hit(awaddr_ff, irq_mask_idx);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_known ? resp_okay : resp_slverr;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // byte 0 write of a register
  function automatic logic wr_hit(input logic [11:0] idx);
    wr_hit = wr_go && wstrb_ff[0] && addr_hit(awaddr_ff, idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  link_ctrl_s ctrl_ff;
  logic [7:0] hide_ff;
  logic [7:0] irq_mask_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff     <= '0;
      hide_ff     <= hide_reset;
      irq_mask_ff <= 8'h00;
    end else begin
      if (wr_hit(link_ctrl_idx)) begin
        ctrl_ff <= link_ctrl_s'(wdata_ff[2:0]);
      end
      if (wr_hit(fault_hide_off)) begin
        hide_ff <= wdata_ff[7:0] & hide_impl;
      end
      if (wr_hit(irq_mask_idx)) begin
        irq_mask_ff <= wdata_ff[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  logic       link_en_d_ff;
  logic       realign_d_ff;
  logic       restart_d_ff;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  logic [7:0] lane_set;
  logic [7:0] lane_clr;
  logic [7:0] stat;
  logic [7:0] lane;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_en_d_ff <= 1'b0;
      realign_d_ff <= 1'b0;
      restart_d_ff <= 1'b0;
    end else begin
      link_en_d_ff <= ctrl_ff.link_en;
      realign_d_ff <= evt_ff.realigned;
      restart_d_ff <= evt_ff.link_restart;
    end
  end

  always_comb begin
    stat_set = 8'h00;
    stat_set[bit_fifo] = |evt_ff.lane_fault;
    stat_set[bit_spll] = evt_ff.spll_unlock;
    if (ctrl_ff.mode_64b66b) begin
      stat_set[bit_link] = (ctrl_ff.link_en && !link_en_d_ff)
                         || (evt_ff.link_restart && !restart_d_ff);
    end else begin
      stat_set[bit_link] = ctrl_ff.link_en && !evt_ff.link_up_data;
    end
    stat_set[bit_realign] = evt_ff.realigned && !realign_d_ff;
    stat_set[bit_clk] = evt_ff.div_mismatch;
    stat_clr = wr_hit(fault_stat_off) ? (wdata_ff[7:0] & stat_impl) : 8'h00;
    lane_set = evt_ff.lane_fault;
    lane_clr = (wr_hit(lane_fault_off) ? wdata_ff[7:0] : 8'h00)
             | ((wr_hit(fault_stat_off) && wdata_ff[bit_fifo]) ? 8'hff : 8'h00);
  end

  alarm_regbank #(.w(8), .rst(stat_reset)) u_stat (
    .mclk   (mclk),
    .nrst   (nrst),
    .set_in (stat_set & stat_impl),
    .clr_in (stat_clr),
    .flags  (stat)
  );

  alarm_regbank #(.w(8), .rst(lane_reset)) u_lane (
    .mclk   (mclk),
    .nrst   (nrst),
    .set_in (lane_set),
    .clr_in (lane_clr),
    .flags  (lane)
  );

  ////////////////////////////////////////////////////////////////////////////
  // aggregate alarm, pin and interrupt
  logic       agg;
  logic [7:0] irq_stat_ff;
  logic       agg_d_ff;
  assign agg = |(stat & ~hide_ff & stat_impl);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_ff <= 8'h00;
      agg_d_ff    <= 1'b0;
      calibration_status_pin <= 1'b0;
      irq         <= 1'b0;
    end else begin
      agg_d_ff <= agg;
      irq_stat_ff <= (irq_stat_ff & ~(wr_hit(irq_stat_idx) ? wdata_ff[7:0] : 8'h00))
                   | {7'h00, agg && !agg_d_ff};
      calibration_status_pin <= ctrl_ff.agg_pin_sel ? agg : cal_ff;
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rd_val;
  logic        rd_ok;
  assign s_axi_arready = !rvalid_ff;
  always_comb begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    if (addr_hit(s_axi_araddr, agg_alarm_off)) begin
      rd_val = {7'h00, agg};
    end else if (addr_hit(s_axi_araddr, fault_stat_off)) begin
      rd_val = stat | 8'h02;
    end else if (addr_hit(s_axi_araddr, fault_hide_off)) begin
      rd_val = hide_ff | 8'h02;
    end else if (addr_hit(s_axi_araddr, lane_fault_off)) begin
      rd_val = lane;
    end else if (addr_hit(s_axi_araddr, link_ctrl_idx)) begin
      rd_val = {5'h00, ctrl_ff};
    end else if (addr_hit(s_axi_araddr, irq_stat_idx)) begin
      rd_val = irq_stat_ff;
    end else if (addr_hit(s_axi_araddr, irq_mask_idx)) begin
      rd_val = irq_mask_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_val};
      rresp_ff  <= rd_ok ? resp_okay : resp_slverr;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_flags_one: assert property (@(posedge mclk)
    $rose(nrst) |-> (stat & stat_impl) == stat_impl) else $error("flags not set after reset");
  a_fifo_sets: assert property (@(posedge mclk) disable iff (!nrst)
    |evt_ff.lane_fault |=> stat[bit_fifo]) else $error("fifo flag not set");
  a_spll_sets: assert property (@(posedge mclk) disable iff (!nrst)
    evt_ff.spll_unlock |=> stat[bit_spll]) else $error("pll flag not set");
  a_link_8b10b: assert property (@(posedge mclk) disable iff (!nrst)
    !ctrl_ff.mode_64b66b && ctrl_ff.link_en && !evt_ff.link_up_data |=> stat[bit_link])
    else $error("link flag not set");
  a_link_start: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl_ff.mode_64b66b && $rose(ctrl_ff.link_en) |=> stat[bit_link])
    else $error("link start flag not set");
  a_realign_sets: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(evt_ff.realigned) |=> stat[bit_realign]) else $error("realign flag not set");
  a_clk_sets: assert property (@(posedge mclk) disable iff (!nrst)
    evt_ff.div_mismatch |=> stat[bit_clk]) else $error("divider flag not set");
  a_mask_hides: assert property (@(posedge mclk) disable iff (!nrst)
    agg |-> (stat[bit_fifo] && !hide_ff[bit_fifo]) || (stat[bit_spll] && !hide_ff[bit_spll])
         || (stat[bit_link] && !hide_ff[bit_link])
         || (stat[bit_realign] && !hide_ff[bit_realign])
         || (stat[bit_clk] && !hide_ff[bit_clk]))
    else $error("masked flag leaks");
  a_lane_wipe: assert property (@(posedge mclk) disable iff (!nrst)
    wr_hit(fault_stat_off) && wdata_ff[bit_fifo] && evt_ff.lane_fault == 8'h00 |=> lane == 8'h00)
    else $error("lane bits not wiped");
  a_sticky_hold: assert property (@(posedge mclk) disable iff (!nrst)
    stat[bit_clk] && !wr_hit(fault_stat_off) |=> stat[bit_clk]) else $error("flag lost");
  a_agg_pin: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl_ff.agg_pin_sel |=> calibration_status_pin == $past(agg)) else $error("pin wrong");
  c_write: cover property (@(posedge mclk) disable iff (!nrst) wr_go);
  c_irq: cover property (@(posedge mclk) disable iff (!nrst) $rose(irq));
  c_clear: cover property (@(posedge mclk) disable iff (!nrst) $fell(stat[bit_fifo]));
  a_agg_shows: assert property (@(posedge mclk) disable iff (!nrst)
    stat[bit_clk] && !hide_ff[bit_clk] |-> agg) else $error("unmasked flag not shown");
  a_lane_sets: assert property (@(posedge mclk) disable iff (!nrst)
    |evt_ff.lane_fault |=> (lane & $past(evt_ff.lane_fault)) == $past(evt_ff.lane_fault))
    else $error("lane bit not set");
  a_lane_clear: assert property (@(posedge mclk) disable iff (!nrst)
    wr_hit(lane_fault_off) && wdata_ff[0] && !evt_ff.lane_fault[0] |=> !lane[0])
    else $error("lane bit not cleared");
  a_link_restart: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl_ff.mode_64b66b && $rose(evt_ff.link_restart) |=> stat[bit_link])
    else $error("link restart flag not set");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!nrst)
    irq_stat_ff[0] && irq_mask_ff[0] |=> irq) else $error("interrupt not raised");
  c_link_start: cover property (@(posedge mclk) disable iff (!nrst)
    ctrl_ff.mode_64b66b && $rose(ctrl_ff.link_en));
  c_set_wins: cover property (@(posedge mclk) disable iff (!nrst)
    wr_hit(fault_stat_off) && wdata_ff[bit_spll] && evt_ff.spll_unlock);
endmodule

// ---- tb_top.sv ----
// self-checking bench for the serial link alarm monitor
// assumes the alarm_pkg package and the design module compiled before it
`timescale 1ns/100ps
module tb_top;
  import alarm_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  alarm_evt_s  evt, idle;
  logic        cal_status_in = 1'b0;
  logic        calibration_status_pin, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  logic [7:0]  exp_bit [0:5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h08};
  int          n_mismatch = 0, total_checks = 0;

  always #2.5 mclk = ~mclk;

  serial_link_alarm_monitor dut (.mclk(mclk), .nrst(nrst), .evt_in(evt),
    .cal_status_in(cal_status_in), .calibration_status_pin(calibration_status_pin), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
    if (n >= 100) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic rdw(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
    if (n >= 100) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    rdw(a);
    check(nm, rd, {24'h0, exp});
  endtask

  // drive one event source active or back to idle
  task automatic drive_evt(input int i, input logic on);
    alarm_evt_s e;
    e = idle;
    if (on) begin
      case (i)
        0: e.lane_fault = 8'h08;
        1: e.spll_unlock = 1'b1;
        2: e.link_up_data = 1'b0;
        3: e.realigned = 1'b1;
        4: e.div_mismatch = 1'b1;
        default: e.link_restart = 1'b1;
      endcase
    end
    evt <= e;
    wait_cyc(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle = '0;
    idle.link_up_data = 1'b1;
    evt = idle;
    wait_cyc(3);
    nrst <= 1'b1;
    @(posedge mclk);
    rchk("status", 12'hb04, 8'h3f);
    check("rd resp", {30'h0, rsp}, {30'h0, resp_okay});
    rchk("mask", 12'hb08, 8'h3f);
    rchk("lanes", 12'hb10, 8'hff);
    rchk("agg", 12'hb00, 8'h00);
    rchk("unmapped", 12'hb0c, 8'h00);
    check("unmapped resp", {30'h0, rsp}, {30'h0, resp_slverr});
    wr(12'hb08, 32'hff);
    check("wr resp", {30'h0, rsp}, {30'h0, resp_okay});
    rchk("mask rsvd", 12'hb08, 8'h3f);
    wr(12'hb0c, 32'h0);
    check("wr unmapped", {30'h0, rsp}, {30'h0, resp_slverr});
    $display("test reset done");
    // enable the link, then discard stale flags
    // clear after enable
    wr(12'hb20, 32'h4);
    wr(12'hb04, 32'h3f);
    wr(12'hb10, 32'hff);
    rchk("status clr", 12'hb04, 8'h02);
    rchk("lanes clr", 12'hb10, 8'h00);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) begin
        wr(12'hb20, 32'h2);
        wr(12'hb20, 32'h6);
        rchk("link start", 12'hb04, 8'h0a);
        wr(12'hb04, 32'h08);
      end
      drive_evt(i, 1'b1);
      drive_evt(i, 1'b0);
      rchk("flag set", 12'hb04, exp_bit[i] | 8'h02);
      if (i == 0) rchk("lane bit", 12'hb10, 8'h08);
      rchk("agg masked", 12'hb00, 8'h00);
      wr(12'hb08, {24'h0, 8'h3f & ~exp_bit[i]});
      rchk("agg open", 12'hb00, 8'h01);
      wr(12'hb04, {24'h0, exp_bit[i]});
      rchk("flag clr", 12'hb04, 8'h02);
      if (i == 0) rchk("lanes all", 12'hb10, 8'h00);
      rchk("agg clr", 12'hb00, 8'h00);
      wr(12'hb08, 32'h3f);
    end
    $display("test flags done");
    // persisting causes win over the clear write
    wr(12'hb20, 32'h4);
    evt <= '{lane_fault: 8'h01, spll_unlock: 1'b1, link_up_data: 1'b1,
             realigned: 1'b0, link_restart: 1'b0, div_mismatch: 1'b0};
    wait_cyc(6);
    wr(12'hb10, 32'h01);
    rchk("lane persist", 12'hb10, 8'h01);
    wr(12'hb04, 32'h10);
    rchk("set wins", 12'hb04, 8'h32);
    evt <= idle;
    wait_cyc(6);
    wr(12'hb04, 32'h3f);
    rchk("lanes drop", 12'hb10, 8'h00);
    $display("test persist done");
    // aggregate onto the pin and the interrupt line
    wr(12'hb20, 32'h5);
    wr(12'hb28, 32'h1);
    wr(12'hb08, 32'h3e);
    drive_evt(4, 1'b1);
    drive_evt(4, 1'b0);
    check("pin agg", {31'h0, calibration_status_pin}, 32'h1);
    check("irq set", {31'h0, irq}, 32'h1);
    wr(12'hb04, 32'h01);
    wait_cyc(4);
    check("pin clr", {31'h0, calibration_status_pin}, 32'h0);
    check("irq held", {31'h0, irq}, 32'h1);
    wr(12'hb24, 32'h1);
    wait_cyc(4);
    check("irq clr", {31'h0, irq}, 32'h0);
    wr(12'hb20, 32'h4);
    cal_status_in <= 1'b1;
    wait_cyc(6);
    check("pin cal", {31'h0, calibration_status_pin}, 32'h1);
    $display("test pin done");
    close_out();
  end
endmodule
